// ===== bench/wwan_control_indication_tb.sv
// self-checking bench of the wwan control and indication block
module wwan_control_indication_tb
  import wwci_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WAKE = 20;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i, root_complex_mode_i, pcie_reset_n_i, pcie_reset_assert_i, pcie_reset_n_o, pcie_reset_n_oe_o;
  logic pcie_reset_n_sync_o, clk_request_n_i, clk_request_assert_i, clk_request_n_o, clk_request_n_oe_o;
  logic pcie_wake_n_i, pcie_wake_assert_i, pcie_wake_n_o, pcie_wake_n_oe_o, link_side_event_o;
  logic airplane_mode_n_i, positioning_disable_n_i, power_reduction_in_i, wlan_tx_notify_i, sim_powered_i;
  logic positioning_start_cmd_i, positioning_stop_cmd_i, functionality_level_cmd_i, backoff_level_cmd_i;
  logic [FUNC_LVL_W-1:0] functionality_level_i;
  logic [BACKOFF_W-1:0]  backoff_level_i, tx_backoff_o, exp_bo;
  logic unsolicited_result_i, highband_tx_active_i, coexist_serial_rx_i, coexist_msg_tx_i, coexist_serial_tx_o;
  logic coexist_msg_rx_o, radio_enable_o, positioning_run_o, wlan_tx_busy_o, highband_tx_notify_o;
  logic rf_status_lamp_n_o, rf_status_lamp_n_oe_o, host_wake_n_o, host_wake_n_oe_o, host_wake_line;
  logic [3:0]  config_strap_o, config_strap_oe_o;
  logic        air_low, pos_low, dpr_low, wlan_tx, perst_low, peer_wake_low, pos_req, rad;
  logic [2:0]  exp_lvl;
  logic [31:0] rnd;
  int          err_total, cmp_count, n;

  wwci_top #(.WAKE_CYC(WAKE)) DUT (.*);
  wwci_host_model PEER (.air_low_i(air_low), .pos_low_i(pos_low), .dpr_low_i(dpr_low), .wlan_tx_i(wlan_tx),
    .perst_low_i(perst_low), .peer_wake_low_i(peer_wake_low), .perst_oe_i(pcie_reset_n_oe_o),
    .clkreq_oe_i(clk_request_n_oe_o), .pcie_wake_oe_i(pcie_wake_n_oe_o), .host_wake_oe_i(host_wake_n_oe_o),
    .airplane_n_o(airplane_mode_n_i), .positioning_n_o(positioning_disable_n_i),
    .power_reduction_o(power_reduction_in_i), .wlan_notify_o(wlan_tx_notify_i), .pcie_reset_n_o(pcie_reset_n_i),
    .clk_request_n_o(clk_request_n_i), .pcie_wake_n_o(pcie_wake_n_i), .host_wake_n_o(host_wake_line));

  always #5 clk_sys_i = ~clk_sys_i;

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic radio_exp(logic a_lo, logic sim, logic [2:0] lvl);
    return !a_lo && sim && (lvl != FUNC_LVL_RF_OFF);
  endfunction : radio_exp
  function automatic logic [7:0] bo_exp(logic d_lo, logic [7:0] bo);
    return d_lo ? bo : 8'h00;
  endfunction : bo_exp
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic step(input int k);
    repeat (k) @(posedge clk_sys_i);
    #1;
  endtask : step
  task automatic final_report();
    if (err_total == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (5000) @(posedge clk_sys_i);
    err_total++;
    final_report();
  end

  initial begin
    {root_complex_mode_i, pcie_reset_assert_i, clk_request_assert_i, pcie_wake_assert_i} = 4'h0;
    {positioning_start_cmd_i, positioning_stop_cmd_i, functionality_level_cmd_i, backoff_level_cmd_i} = 4'h0;
    {air_low, pos_low, dpr_low, wlan_tx, perst_low, peer_wake_low, pos_req} = 7'h00;
    {unsolicited_result_i, highband_tx_active_i, coexist_serial_rx_i, coexist_msg_tx_i} = 4'h0;
    functionality_level_i = 3'h0;
    backoff_level_i = 8'h00;
    sim_powered_i = 1'b1;
    sys_rst_i = 1'b1;
    rnd = 32'he63e_1269;
    exp_lvl = FUNC_LVL_RST;
    repeat (3) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    step(4);
    chk("strap_oe", config_strap_oe_o, 8'h02);
    chk("strap_lvl", config_strap_o, 8'h00);
    for (int i = 0; i < 40; i++) begin
      @(posedge clk_sys_i);
      rnd = lfsr(rnd);
      air_low <= rnd[0] & rnd[1];
      pos_low <= rnd[2] & rnd[3];
      dpr_low <= rnd[4];
      wlan_tx <= rnd[5];
      sim_powered_i <= rnd[6] | rnd[7];
      highband_tx_active_i <= rnd[8];
      coexist_serial_rx_i <= rnd[9];
      coexist_msg_tx_i <= rnd[10];
      functionality_level_cmd_i <= rnd[11];
      functionality_level_i <= rnd[12] ? FUNC_LVL_RF_OFF : rnd[15:13];
      backoff_level_cmd_i <= 1'b1;
      backoff_level_i <= rnd[23:16];
      positioning_start_cmd_i <= rnd[24] | (i < 2);
      positioning_stop_cmd_i <= (rnd[25] & rnd[26]) | (i == 1);
      if (rnd[11]) exp_lvl = rnd[12] ? FUNC_LVL_RF_OFF : rnd[15:13];
      exp_bo = rnd[23:16];
      if ((rnd[25] & rnd[26]) | (i == 1)) pos_req = 1'b0;
      else if (rnd[24] | (i < 2)) pos_req = 1'b1;
      @(posedge clk_sys_i);
      {positioning_start_cmd_i, positioning_stop_cmd_i, functionality_level_cmd_i, backoff_level_cmd_i} <= 4'h0;
      step(4);
      rad = radio_exp(air_low, sim_powered_i, exp_lvl);
      chk("radio", radio_enable_o, rad);
      chk("lamp_oe", rf_status_lamp_n_oe_o, rad);
      chk("lamp_lvl", rf_status_lamp_n_o, 8'h00);
      chk("pos_run", positioning_run_o, pos_req & !pos_low);
      chk("backoff", tx_backoff_o, bo_exp(dpr_low, exp_bo));
      chk("hb_notify", highband_tx_notify_o, highband_tx_active_i & rad);
      chk("wlan_busy", wlan_tx_busy_o, wlan_tx);
      chk("coex_rx", coexist_msg_rx_o, coexist_serial_rx_i);
      chk("coex_tx", coexist_serial_tx_o, coexist_msg_tx_i);
    end
    chk("wake_idle", host_wake_line, 8'h01);
    @(posedge clk_sys_i);
    unsolicited_result_i <= 1'b1;
    n = 0;
    for (int j = 0; j < WAKE + 10; j++) begin
      @(posedge clk_sys_i);
      unsolicited_result_i <= (j == 5);
      #1;
      if (host_wake_n_oe_o === 1'b1 && host_wake_line === 1'b0) n++;
    end
    chk("wake_len", n[7:0], 8'(WAKE));
    chk("wake_rel", host_wake_line, 8'h01);
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_sys_i);
      root_complex_mode_i <= m[1];
      {pcie_reset_assert_i, clk_request_assert_i, pcie_wake_assert_i} <= {3{m[0]}};
      perst_low <= !m[1] & m[0];
      peer_wake_low <= m[1] & m[0];
      step(4);
      chk("perst_oe", pcie_reset_n_oe_o, m[1] & m[0]);
      chk("perst_lvl", pcie_reset_n_sync_o, !m[0]);
      chk("clkreq_oe", clk_request_n_oe_o, !m[1] & m[0]);
      chk("pwake_oe", pcie_wake_n_oe_o, !m[1] & m[0]);
      chk("link_evt", link_side_event_o, m[1] & m[0]);
      chk("pin_low", {pcie_reset_n_o, clk_request_n_o, pcie_wake_n_o, host_wake_n_o}, 8'h00);
    end
    final_report();
  end
endmodule : wwan_control_indication_tb

// ===== bench/wwci_host_model.sv
// host and wlan side model that drives and pulls up the sideband pins
module wwci_host_model (
  input  wire logic air_low_i,
  input  wire logic pos_low_i,
  input  wire logic dpr_low_i,
  input  wire logic wlan_tx_i,
  input  wire logic perst_low_i,
  input  wire logic peer_wake_low_i,
  input  wire logic perst_oe_i,
  input  wire logic clkreq_oe_i,
  input  wire logic pcie_wake_oe_i,
  input  wire logic host_wake_oe_i,
  output logic      airplane_n_o,
  output logic      positioning_n_o,
  output logic      power_reduction_o,
  output logic      wlan_notify_o,
  output logic      pcie_reset_n_o,
  output logic      clk_request_n_o,
  output logic      pcie_wake_n_o,
  output logic      host_wake_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // released control pins rise to the device pull-ups
  assign airplane_n_o      = !air_low_i;
  assign positioning_n_o   = !pos_low_i;
  assign power_reduction_o = !dpr_low_i;
  assign wlan_notify_o     = wlan_tx_i;
  // push-pull host drive of reset in endpoint mode and of wake in root-complex mode, device open drain otherwise
  assign pcie_reset_n_o    = !(perst_low_i || perst_oe_i);
  assign clk_request_n_o   = !clkreq_oe_i;
  assign pcie_wake_n_o     = !(peer_wake_low_i || pcie_wake_oe_i);
  assign host_wake_n_o     = !host_wake_oe_i;
endmodule : wwci_host_model

// ===== verilog/wwci_pkg.sv
// constants and types of the wwan control and indication block
// Overview of operation
// - In endpoint mode the reset pin is an input, in root-complex mode it is driven open drain, low meaning reset.
// - Clock request and wake are open-drain low outputs in endpoint mode, inputs in root-complex mode; endpoint is default.
// - An undriven airplane-mode input reads inactive because of an internal pull-up.
// - While airplane mode is low the radio transmit and receive stay disabled.
// - The positioning-disable input is pulled up, and low turns positioning off.
// - Positioning runs only with the disable input high and a start command given since the last stop.
// - The lamp output is pulled low while the radio function is on.
// - The lamp is released when the SIM is unpowered, airplane mode is low or functionality level 4 is set.
// - An unsolicited result drives host wake low for one second, then releases it.
// - Host wake is open drain with the pull-up on the host, released in idle and sleep.
// - Power reduction high gives no backoff, low applies the software-set maximum backoff.
// - The high-band notify output is asserted while transmitting in band n79.
// - The coexistence serial pair serves only coexistence messaging.
// - Strap 1 is grounded and straps 0, 2 and 3 are left open.
package wwci_pkg;
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned WAKE_PULSE_SEC   = 1;
  localparam int unsigned WAKE_PULSE_CYC   = (WAKE_PULSE_SEC * 1000 * 1000 * 1000) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_CNT_W       = 27;
  localparam int unsigned FUNC_LVL_W       = 3;
  localparam logic [2:0]  FUNC_LVL_RF_OFF  = 3'h4;
  localparam logic [2:0]  FUNC_LVL_RST     = 3'h1;
  localparam int unsigned BACKOFF_W        = 8;
  localparam logic [7:0]  BACKOFF_RST      = 8'h00;
  localparam logic [3:0]  STRAP_GROUNDED   = 4'h2;
  localparam logic [1:0]  SYNC_RST         = 2'h3;
  typedef enum logic [1:0] {
    WWCI_WAKE_IDLE  = 2'b00,
    WWCI_WAKE_PULSE = 2'b01
  } wwci_wake_e;
endpackage : wwci_pkg

// ===== verilog/wwci_sync.sv
// two-flop synchroniser for one level input
module wwci_sync
  import wwci_pkg::*;
(
  input  wire logic clk_sys_i,
  input  wire logic sys_rst_i,
  input  wire logic async_i,
  output logic      sync_o
);
  logic [1:0] stage_reg;
  logic [1:0] stage_next;

  always_comb begin
    stage_next = {stage_reg[0], async_i};
  end

  // reset to the high level, inactive (pulled-up) for every input except wlan_tx_notify_i
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stage_reg <= SYNC_RST;
    end else begin
      stage_reg <= stage_next;
    end
  end

  assign sync_o = stage_reg[1];
endmodule : wwci_sync

// ===== verilog/wwci_top.sv
// wwan control and indication sideband logic
module wwci_top
  import wwci_pkg::*;
#(
  parameter int unsigned WAKE_CYC = WAKE_PULSE_CYC
) (
  input  wire logic                  clk_sys_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  root_complex_mode_i,
  input  wire logic                  pcie_reset_n_i,
  input  wire logic                  pcie_reset_assert_i,
  output logic                       pcie_reset_n_o,
  output logic                       pcie_reset_n_oe_o,
  output logic                       pcie_reset_n_sync_o,
  input  wire logic                  clk_request_n_i,
  input  wire logic                  clk_request_assert_i,
  output logic                       clk_request_n_o,
  output logic                       clk_request_n_oe_o,
  input  wire logic                  pcie_wake_n_i,
  input  wire logic                  pcie_wake_assert_i,
  output logic                       pcie_wake_n_o,
  output logic                       pcie_wake_n_oe_o,
  output logic                       link_side_event_o,
  input  wire logic                  airplane_mode_n_i,
  input  wire logic                  positioning_disable_n_i,
  input  wire logic                  power_reduction_in_i,
  input  wire logic                  wlan_tx_notify_i,
  input  wire logic                  sim_powered_i,
  input  wire logic                  positioning_start_cmd_i,
  input  wire logic                  positioning_stop_cmd_i,
  input  wire logic                  functionality_level_cmd_i,
  input  wire logic [FUNC_LVL_W-1:0] functionality_level_i,
  input  wire logic                  backoff_level_cmd_i,
  input  wire logic [BACKOFF_W-1:0]  backoff_level_i,
  input  wire logic                  unsolicited_result_i,
  input  wire logic                  highband_tx_active_i,
  input  wire logic                  coexist_serial_rx_i,
  input  wire logic                  coexist_msg_tx_i,
  output logic                       coexist_serial_tx_o,
  output logic                       coexist_msg_rx_o,
  output logic                       radio_enable_o,
  output logic                       positioning_run_o,
  output logic [BACKOFF_W-1:0]       tx_backoff_o,
  output logic                       wlan_tx_busy_o,
  output logic                       highband_tx_notify_o,
  output logic                       rf_status_lamp_n_o,
  output logic                       rf_status_lamp_n_oe_o,
  output logic                       host_wake_n_o,
  output logic                       host_wake_n_oe_o,
  output logic [3:0]                 config_strap_o,
  output logic [3:0]                 config_strap_oe_o
);
  logic airplane_s, posdis_s, pwrred_s, wlan_s, perst_s, wake_s;

  wwci_sync u_sync_air (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .async_i(airplane_mode_n_i), .sync_o(airplane_s));
  wwci_sync u_sync_pos (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .async_i(positioning_disable_n_i), .sync_o(posdis_s));
  wwci_sync u_sync_pwr (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .async_i(power_reduction_in_i), .sync_o(pwrred_s));
  wwci_sync u_sync_wln (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .async_i(wlan_tx_notify_i), .sync_o(wlan_s));
  wwci_sync u_sync_rst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .async_i(pcie_reset_n_i), .sync_o(perst_s));
  wwci_sync u_sync_wak (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .async_i(pcie_wake_n_i), .sync_o(wake_s));

  // ---- pcie sideband pin direction
  always_comb begin
    pcie_reset_n_o      = 1'b0;
    pcie_reset_n_oe_o   = root_complex_mode_i & pcie_reset_assert_i;
    pcie_reset_n_sync_o = root_complex_mode_i ? ~pcie_reset_assert_i : perst_s;
    clk_request_n_o     = 1'b0;
    clk_request_n_oe_o  = ~root_complex_mode_i & clk_request_assert_i;
    pcie_wake_n_o       = 1'b0;
    pcie_wake_n_oe_o    = ~root_complex_mode_i & pcie_wake_assert_i;
    link_side_event_o   = root_complex_mode_i & ~wake_s;
  end

  // ---- software-held state
  logic                  pos_req_reg, pos_req_next;
  logic [FUNC_LVL_W-1:0] func_lvl_reg, func_lvl_next;
  logic [BACKOFF_W-1:0]  backoff_reg, backoff_next;

  always_comb begin
    pos_req_next  = pos_req_reg;
    func_lvl_next = func_lvl_reg;
    backoff_next  = backoff_reg;
    if (positioning_stop_cmd_i) begin
      pos_req_next = 1'b0;
    end else if (positioning_start_cmd_i) begin
      pos_req_next = 1'b1;
    end
    if (functionality_level_cmd_i) begin
      func_lvl_next = functionality_level_i;
    end
    if (backoff_level_cmd_i) begin
      backoff_next = backoff_level_i;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pos_req_reg  <= 1'b0;
      func_lvl_reg <= FUNC_LVL_RST;
      backoff_reg  <= BACKOFF_RST;
    end else begin
      pos_req_reg  <= pos_req_next;
      func_lvl_reg <= func_lvl_next;
      backoff_reg  <= backoff_next;
    end
  end

  // ---- radio, positioning, backoff, coexistence outputs
  logic                 radio_on;
  logic                 radio_reg, pos_reg, hb_reg, wlan_reg;
  logic                 radio_next, pos_next, hb_next, wlan_next;
  logic [BACKOFF_W-1:0] txb_reg, txb_next;

  assign radio_on = airplane_s & sim_powered_i & (func_lvl_reg != FUNC_LVL_RF_OFF);

  always_comb begin
    radio_next = radio_on;
    pos_next   = posdis_s & pos_req_reg;
    txb_next   = pwrred_s ? BACKOFF_RST : backoff_reg;
    hb_next    = highband_tx_active_i & radio_on;
    wlan_next  = wlan_s;
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      radio_reg <= 1'b0;
      pos_reg   <= 1'b0;
      txb_reg   <= BACKOFF_RST;
      hb_reg    <= 1'b0;
      wlan_reg  <= 1'b0;
    end else begin
      radio_reg <= radio_next;
      pos_reg   <= pos_next;
      txb_reg   <= txb_next;
      hb_reg    <= hb_next;
      wlan_reg  <= wlan_next;
    end
  end

  assign radio_enable_o        = radio_reg;
  assign positioning_run_o     = pos_reg;
  assign tx_backoff_o          = txb_reg;
  assign highband_tx_notify_o  = hb_reg;
  assign wlan_tx_busy_o        = wlan_reg;
  assign rf_status_lamp_n_o    = 1'b0;
  assign rf_status_lamp_n_oe_o = radio_reg;
  // coexistence pair routed only to the coexistence messaging port
  assign coexist_serial_tx_o   = coexist_msg_tx_i;
  assign coexist_msg_rx_o      = coexist_serial_rx_i;
  assign config_strap_o        = 4'h0;
  assign config_strap_oe_o     = STRAP_GROUNDED;

  // ---- host wake pulse
  wwci_wake_e            wake_st_reg, wake_st_next;
  logic [WAKE_CNT_W-1:0] wake_cnt_reg, wake_cnt_next;

  always_comb begin
    wake_st_next  = wake_st_reg;
    wake_cnt_next = wake_cnt_reg;
    case (wake_st_reg)
      WWCI_WAKE_IDLE: begin
        if (unsolicited_result_i) begin
          wake_st_next  = WWCI_WAKE_PULSE;
          wake_cnt_next = WAKE_CNT_W'(WAKE_CYC - 1);
        end
      end
      WWCI_WAKE_PULSE: begin
        if (wake_cnt_reg == '0) begin
          wake_st_next = WWCI_WAKE_IDLE;
        end else begin
          wake_cnt_next = wake_cnt_reg - 1'b1;
        end
      end
      default: begin
        wake_st_next  = WWCI_WAKE_IDLE;
        wake_cnt_next = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wake_st_reg  <= WWCI_WAKE_IDLE;
      wake_cnt_reg <= '0;
    end else begin
      wake_st_reg  <= wake_st_next;
      wake_cnt_reg <= wake_cnt_next;
    end
  end

  assign host_wake_n_o    = 1'b0;
  assign host_wake_n_oe_o = (wake_st_reg == WWCI_WAKE_PULSE);

  // checker helper: cycles the wake pin has been held low so far
  logic [WAKE_CNT_W-1:0] wake_len_reg, wake_len_next;

  always_comb begin
    wake_len_next = host_wake_n_oe_o ? wake_len_reg + 1'b1 : '0;
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wake_len_reg <= '0;
    end else begin
      wake_len_reg <= wake_len_next;
    end
  end

  // ---- assertions
  lamp_follows_radio_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    rf_status_lamp_n_oe_o == ($past(radio_on) && !$past(sys_rst_i))) else $error("lamp does not follow radio");
  airplane_kills_radio_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !airplane_s |=> !radio_enable_o) else $error("radio on in airplane mode");
  level4_releases_lamp_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (func_lvl_reg == FUNC_LVL_RF_OFF) || !sim_powered_i |=> !rf_status_lamp_n_oe_o) else $error("lamp lit when off");
  pos_disable_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !posdis_s |=> !positioning_run_o) else $error("positioning runs while disabled");
  pos_stop_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    positioning_stop_cmd_i |=> ##1 !positioning_run_o) else $error("positioning runs after stop");
  wake_pulse_start_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !host_wake_n_oe_o && unsolicited_result_i |=> host_wake_n_oe_o) else $error("wake pulse missing");
  wake_pulse_end_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $fell(host_wake_n_oe_o) |-> wake_len_reg == WAKE_CNT_W'(WAKE_CYC)) else $error("wake pulse length wrong");
  backoff_select_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    pwrred_s |=> tx_backoff_o == BACKOFF_RST) else $error("backoff applied while high");
  backoff_apply_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !pwrred_s |=> tx_backoff_o == $past(backoff_reg)) else $error("backoff missing while low");
  ep_reset_input_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !root_complex_mode_i |-> !pcie_reset_n_oe_o) else $error("reset driven in endpoint");
  rc_no_clkreq_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    root_complex_mode_i |-> !clk_request_n_oe_o && !pcie_wake_n_oe_o) else $error("input pin driven");
endmodule : wwci_top
